/* tcs_pkg.sv */
// Constants and types shared by the tracking calibration scheduler
// Operation
// RULE1: Receive correction tracking runs while receivers active
// RULE2: High overload holds receive coefficients unchanged
// RULE3: TDD receive tracking only in receive periods
// RULE4: Single enabled receiver is the only one tracked
// RULE5: Observation tracking needs observation channel, period
// RULE6: Transmit tracking needs transmitter and released path
// RULE7: Tracking and predistortion never share the path
// RULE8: Leakage tracking needs amplifier on, interleaved captures
// RULE9: Host provides feedback path when path granted
// RULE10: Host follows observe choice output when sharing
// RULE11: Channel estimate adapts slowly, 67% in 200s; the divider and shift here give about 63% in 200s
// RULE12: Estimate reset targets one or both transmitters
// RULE13: Six instances after reset only estimate channel
// RULE14: Leakage correction frozen during estimation window
// RULE15: Afterwards each leakage instance updates correction
// RULE16: Host resets estimate on LO or path change
// RULE17: Chains enabled by register or enable pins
// RULE18: Observation path by register or four pins
// RULE19: Acknowledge outputs confirm activated chains
// RULE20: Observe choice output names transmitter under calibration
// RULE21: One error interrupt, maskable, identifiable sources
// RULE22: Host reinitializes device on calibration processor error
// RULE23: Observe choice low means transmitter one
// RULE24: Host settles feedback path within 35 us
// RULE25: Unmet tracking stays pending, runs when possible
`default_nettype none
package tcs_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned SETTLE_US = 35;
	localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int unsigned ADAPT_SEC = 200;
	localparam int unsigned ADAPT_SHIFT = 8;
	localparam longint unsigned ADAPT_TICK_LONG =
		(longint'(ADAPT_SEC) * longint'(CLK_HZ)) >> ADAPT_SHIFT;
	localparam int unsigned ADAPT_TICK_CYC = 32'(ADAPT_TICK_LONG);
	localparam int unsigned EST_INSTANCES = 6;
	localparam int unsigned INST_CYC = 64;
	localparam int unsigned COEF_SHIFT = 2;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CHAIN = 8'h04;
	localparam logic [7:0] ADDR_EST_RESET = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_ERR_STAT = 8'h10;
	localparam logic [7:0] ADDR_ERR_MASK = 8'h14;
	localparam logic [7:0] ADDR_LOL_COEF = 8'h18;

	localparam int CTRL_TDD = 0;
	localparam int CTRL_CHAIN_PIN = 1;
	localparam int CTRL_ORX_PIN = 2;
	localparam int CTRL_SEL_INV = 3;
	localparam int CHAIN_RX = 0;
	localparam int CHAIN_TX = 2;
	localparam int CHAIN_ORX = 4;
	localparam int CHAIN_REL = 6;
	localparam int CHAIN_DPD = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CHAIN_RST = 8'h00;
	localparam logic [3:0] ERR_MASK_RST = 4'hf;

	localparam int ERR_W = 4;
	localparam int ERR_PROC = 0;
	localparam int ERR_PLL = 1;
	localparam int ERR_LINK = 2;
	localparam int ERR_CAL = 3;

	localparam logic [1:0] TGT_TX1 = 2'h1;
	localparam logic [1:0] TGT_TX2 = 2'h2;
	localparam logic [1:0] TGT_BOTH_TRANSMITTERS = 2'h3;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_DPD,
		SEQ_SETTLE,
		SEQ_RUN
	} tcs_seq_t;
endpackage
`default_nettype wire

/* tcs_scheduler.sv */
// Tracking calibration scheduler with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module tcs_scheduler #(
	parameter int unsigned ADAPT_TICK = tcs_pkg::ADAPT_TICK_CYC,
	parameter int unsigned INST_LEN = tcs_pkg::INST_CYC,
	parameter int unsigned SETTLE_LEN = tcs_pkg::SETTLE_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] rx_chain_enable_pin,
	input wire logic [1:0] tx_chain_enable_pin,
	input wire logic [3:0] orx_gpio_pin,
	input wire logic tdd_rx_period,
	input wire logic tdd_orx_period,
	input wire logic overload_high,
	input wire logic pa_active,
	input wire logic dpd_capture_req,
	input wire logic signed [15:0] lol_meas_tx1,
	input wire logic signed [15:0] lol_meas_tx2,
	input wire logic [3:0] err_src_in,
	output logic [5:0] chain_ack_out,
	output logic [1:0] rx_qec_run_out,
	output logic [1:0] rx_qec_update_out,
	output logic [1:0] orx_qec_run_out,
	output logic [1:0] tx_qec_run_out,
	output logic [1:0] tx_lol_run_out,
	output logic dpd_grant_out,
	output logic cal_path_grant_out,
	output logic tx_observe_choice_out,
	output logic signed [15:0] lol_coef_tx1,
	output logic signed [15:0] lol_coef_tx2,
	output logic general_error_irq
);
	localparam int TW = $clog2(ADAPT_TICK + 1);

	// Register bus
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic wr_acc;
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic [7:0] chain_ff, nxt_chain;
	logic [3:0] err_mask_ff, nxt_err_mask;
	logic [1:0] est_cmd;

	// Chain resolution
	logic [1:0] rx_act, tx_act, orx_act;
	logic released, dpd_req, tdd;

	// Sequencer
	tcs_pkg::tcs_seq_t seq_ff, nxt_seq;
	logic [1:0] cur_ff, nxt_cur;
	logic [1:0] rr_ff, nxt_rr;
	logic [15:0] tmr_ff, nxt_tmr;
	logic sel_ff, nxt_sel;
	logic [3:0] pend_ff, nxt_pend;
	logic [3:0] elig;
	logic [1:0] lol_done;

	// Estimate and correction
	logic [2:0] cnt_ff [2], nxt_cnt [2];
	logic signed [15:0] est_ff [2], nxt_est [2];
	logic signed [15:0] lat_ff [2], nxt_lat [2];
	logic signed [15:0] coef_ff [2], nxt_coef [2];
	logic signed [15:0] meas [2];
	logic [TW-1:0] tick_ff, nxt_tick;
	logic tick;

	// Errors and registered outputs
	logic [3:0] err_stat_ff, nxt_err_stat;
	logic irq_ff, nxt_irq;
	logic [6:0] outs_ff, nxt_outs;

	assign meas[0] = lol_meas_tx1;
	assign meas[1] = lol_meas_tx2;

	// One wait state per access; the answer edge is the accept edge
	always_comb begin
		nxt_ack = (avs_read | avs_write) & ~ack_ff;
		nxt_rdata = rdata_ff;
		if (avs_read & ~ack_ff) begin
			case (avs_address)
				tcs_pkg::ADDR_CTRL: nxt_rdata = {24'h00_0000, ctrl_ff};
				tcs_pkg::ADDR_CHAIN: nxt_rdata = {24'h00_0000, chain_ff};
				tcs_pkg::ADDR_EST_RESET:
					nxt_rdata = {26'h000_0000, cnt_ff[1], cnt_ff[0]};
				tcs_pkg::ADDR_STATUS: nxt_rdata = {8'h00, pend_ff,
					2'(seq_ff), sel_ff, irq_ff, 8'h00, orx_act, tx_act,
					rx_act, 2'h0};
				tcs_pkg::ADDR_ERR_STAT: nxt_rdata = {28'h000_0000, err_stat_ff};
				tcs_pkg::ADDR_ERR_MASK: nxt_rdata = {28'h000_0000, err_mask_ff};
				tcs_pkg::ADDR_LOL_COEF: nxt_rdata = {coef_ff[1], coef_ff[0]};
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata = rdata_ff;
	assign wr_acc = avs_write & ack_ff & avs_byteenable[0];

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_chain = chain_ff;
		nxt_err_mask = err_mask_ff;
		est_cmd = 2'h0;
		if (wr_acc) begin
			case (avs_address)
				tcs_pkg::ADDR_CTRL: nxt_ctrl = avs_writedata[7:0];
				tcs_pkg::ADDR_CHAIN: nxt_chain = avs_writedata[7:0];
				tcs_pkg::ADDR_EST_RESET: est_cmd = avs_writedata[1:0]; // see RULE12
				tcs_pkg::ADDR_ERR_MASK: nxt_err_mask = avs_writedata[3:0];
				default: nxt_ctrl = ctrl_ff;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			ctrl_ff <= tcs_pkg::CTRL_RST;
			chain_ff <= tcs_pkg::CHAIN_RST;
			err_mask_ff <= tcs_pkg::ERR_MASK_RST;
		end else begin
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
			ctrl_ff <= nxt_ctrl;
			chain_ff <= nxt_chain;
			err_mask_ff <= nxt_err_mask;
		end
	end

	// Rx/tx chains and the observation path each come from pins or from the register, selected separately
	always_comb begin
		tdd = ctrl_ff[tcs_pkg::CTRL_TDD];
		if (ctrl_ff[tcs_pkg::CTRL_CHAIN_PIN]) begin
			rx_act = rx_chain_enable_pin; // see RULE17
			tx_act = tx_chain_enable_pin;
		end else begin
			rx_act = chain_ff[tcs_pkg::CHAIN_RX +: 2];
			tx_act = chain_ff[tcs_pkg::CHAIN_TX +: 2];
		end
		if (ctrl_ff[tcs_pkg::CTRL_ORX_PIN]) begin
			orx_act = orx_gpio_pin[1:0]; // see RULE18
			released = orx_gpio_pin[2];
			dpd_req = dpd_capture_req | orx_gpio_pin[3];
		end else begin
			orx_act = chain_ff[tcs_pkg::CHAIN_ORX +: 2];
			released = chain_ff[tcs_pkg::CHAIN_REL];
			dpd_req = dpd_capture_req | chain_ff[tcs_pkg::CHAIN_DPD];
		end
		// Index bit 1 selects leakage, bit 0 the transmitter
		elig[0] = tx_act[0] & released; // see RULE6
		elig[1] = tx_act[1] & released;
		elig[2] = tx_act[0] & released & pa_active; // see RULE8
		elig[3] = tx_act[1] & released & pa_active;
	end

	// Path sequencer: predistortion captures only between instances
	always_comb begin
		logic [1:0] idx;
		logic found;
		logic [1:0] pick;
		idx = 2'h0;
		found = 1'b0;
		pick = 2'h0;
		nxt_seq = seq_ff;
		nxt_cur = cur_ff;
		nxt_rr = rr_ff;
		nxt_tmr = tmr_ff;
		nxt_sel = sel_ff;
		nxt_pend = pend_ff;
		lol_done = 2'h0;
		for (int k = 0; k < 4; k++) begin
			idx = rr_ff + 2'(k);
			if (!found && elig[idx] && pend_ff[idx]) begin
				found = 1'b1;
				pick = idx;
			end
		end
		case (seq_ff)
			tcs_pkg::SEQ_IDLE: begin
				if (dpd_req) begin
					nxt_seq = tcs_pkg::SEQ_DPD; // see RULE7
				end else if (found) begin
					nxt_cur = pick;
					nxt_rr = pick + 2'h1;
					if (pick[1] && pick[0] != sel_ff) begin
						// Host needs time to move the external switch
						nxt_sel = pick[0]; // see RULE20
						nxt_tmr = 16'(SETTLE_LEN - 1);
						nxt_seq = tcs_pkg::SEQ_SETTLE;
					end else begin
						nxt_tmr = 16'(INST_LEN - 1);
						nxt_seq = tcs_pkg::SEQ_RUN;
					end
				end else begin
					// Round complete or nothing can run: schedule all again
					nxt_pend = 4'hf;
				end
			end
			tcs_pkg::SEQ_DPD: begin
				if (!dpd_req) begin
					nxt_seq = tcs_pkg::SEQ_IDLE;
				end
			end
			tcs_pkg::SEQ_SETTLE: begin
				if (!elig[cur_ff]) begin
					nxt_seq = tcs_pkg::SEQ_IDLE; // see RULE25
				end else if (tmr_ff == 16'h0000) begin
					nxt_tmr = 16'(INST_LEN - 1);
					nxt_seq = tcs_pkg::SEQ_RUN;
				end else begin
					nxt_tmr = tmr_ff - 16'h0001;
				end
			end
			tcs_pkg::SEQ_RUN: begin
				if (!elig[cur_ff]) begin
					// Aborted instance stays pending
					nxt_seq = tcs_pkg::SEQ_IDLE; // see RULE25
				end else if (tmr_ff == 16'h0000) begin
					nxt_pend[cur_ff] = 1'b0;
					if (cur_ff[1]) begin
						lol_done[cur_ff[0]] = 1'b1;
					end
					nxt_seq = tcs_pkg::SEQ_IDLE;
				end else begin
					nxt_tmr = tmr_ff - 16'h0001;
				end
			end
			default: nxt_seq = tcs_pkg::SEQ_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			seq_ff <= tcs_pkg::SEQ_IDLE;
			cur_ff <= 2'h0;
			rr_ff <= 2'h0;
			tmr_ff <= 16'h0000;
			sel_ff <= 1'b0;
			pend_ff <= 4'hf;
		end else begin
			seq_ff <= nxt_seq;
			cur_ff <= nxt_cur;
			rr_ff <= nxt_rr;
			tmr_ff <= nxt_tmr;
			sel_ff <= nxt_sel;
			pend_ff <= nxt_pend;
		end
	end

	assign dpd_grant_out = (seq_ff == tcs_pkg::SEQ_DPD); // see RULE7
	assign cal_path_grant_out = (seq_ff == tcs_pkg::SEQ_SETTLE) |
		(seq_ff == tcs_pkg::SEQ_RUN);
	always_comb begin
		tx_qec_run_out = 2'h0;
		tx_lol_run_out = 2'h0;
		if (seq_ff == tcs_pkg::SEQ_RUN) begin
			if (cur_ff[1]) begin
				tx_lol_run_out[cur_ff[0]] = 1'b1;
			end else begin
				tx_qec_run_out[cur_ff[0]] = 1'b1;
			end
		end
	end

	// Slow adaptation divider
	always_comb begin
		tick = (tick_ff == TW'(ADAPT_TICK - 1));
		nxt_tick = tick ? '0 : tick_ff + TW'(1);
	end

	// Estimate window and leakage correction per transmitter
	always_comb begin
		logic signed [15:0] err;
		err = 16'sh0000;
		for (int i = 0; i < 2; i++) begin
			nxt_cnt[i] = cnt_ff[i];
			nxt_est[i] = est_ff[i];
			nxt_lat[i] = lat_ff[i];
			nxt_coef[i] = coef_ff[i];
			if (lol_done[i]) begin
				nxt_lat[i] = meas[i];
			end
			if (est_cmd[i]) begin
				// A new command restarts the window even mid-window
				nxt_cnt[i] = 3'(tcs_pkg::EST_INSTANCES); // see RULE13
			end else if (lol_done[i] && cnt_ff[i] != 3'h0) begin
				nxt_cnt[i] = cnt_ff[i] - 3'h1; // see RULE14
				if (cnt_ff[i] == 3'(tcs_pkg::EST_INSTANCES)) begin
					nxt_est[i] = meas[i];
				end else begin
					nxt_est[i] = 16'((17'(est_ff[i]) + 17'(meas[i])) >>> 1);
				end
			end else if (lol_done[i]) begin
				err = meas[i] - est_ff[i];
				nxt_coef[i] = coef_ff[i] -
					(err >>> tcs_pkg::COEF_SHIFT); // see RULE15
			end else if (tick && cnt_ff[i] == 3'h0) begin
				err = lat_ff[i] - est_ff[i];
				nxt_est[i] = est_ff[i] +
					(err >>> tcs_pkg::ADAPT_SHIFT); // see RULE11
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tick_ff <= '0;
			for (int i = 0; i < 2; i++) begin
				cnt_ff[i] <= 3'h0;
				est_ff[i] <= 16'sh0000;
				lat_ff[i] <= 16'sh0000;
				coef_ff[i] <= 16'sh0000;
			end
		end else begin
			tick_ff <= nxt_tick;
			for (int i = 0; i < 2; i++) begin
				cnt_ff[i] <= nxt_cnt[i];
				est_ff[i] <= nxt_est[i];
				lat_ff[i] <= nxt_lat[i];
				coef_ff[i] <= nxt_coef[i];
			end
		end
	end

	assign lol_coef_tx1 = coef_ff[0];
	assign lol_coef_tx2 = coef_ff[1];

	// Error capture: a new event beats a clear in the same cycle
	always_comb begin
		nxt_err_stat = err_stat_ff;
		if (wr_acc && avs_address == tcs_pkg::ADDR_ERR_STAT) begin
			nxt_err_stat = err_stat_ff & ~avs_writedata[3:0];
		end
		nxt_err_stat = nxt_err_stat | err_src_in; // see RULE21
		nxt_irq = |(err_stat_ff & ~err_mask_ff);
	end

	// Receive and observation tracking, acknowledges
	always_comb begin
		logic [1:0] rx_run;
		logic [1:0] orx_run;
		rx_run = rx_act & {2{~tdd | tdd_rx_period}}; // see RULE1 RULE3 RULE4
		orx_run = orx_act & {2{~tdd | tdd_orx_period}}; // see RULE5
		nxt_outs = {rx_run & {2{~overload_high}}, // see RULE2
			orx_run, rx_run,
			sel_ff ^ ctrl_ff[tcs_pkg::CTRL_SEL_INV]}; // see RULE23
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			err_stat_ff <= 4'h0;
			irq_ff <= 1'b0;
			outs_ff <= 7'h00;
			chain_ack_out <= 6'h00;
		end else begin
			err_stat_ff <= nxt_err_stat;
			irq_ff <= nxt_irq;
			outs_ff <= nxt_outs;
			chain_ack_out <= {orx_act, tx_act, rx_act}; // see RULE19
		end
	end

	assign general_error_irq = irq_ff;
	assign rx_qec_update_out = outs_ff[6:5];
	assign orx_qec_run_out = outs_ff[4:3];
	assign rx_qec_run_out = outs_ff[2:1];
	assign tx_observe_choice_out = outs_ff[0];
endmodule
`default_nettype wire

/* tcs_sched_properties.sv */
// Port assertions for the tracking calibration scheduler
`timescale 1ns/1ps
`default_nettype none
module tcs_sched_props (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic overload_high,
	input wire logic pa_active,
	input wire logic [5:0] chain_ack_out,
	input wire logic [1:0] rx_qec_run_out,
	input wire logic [1:0] rx_qec_update_out,
	input wire logic [1:0] orx_qec_run_out,
	input wire logic [1:0] tx_qec_run_out,
	input wire logic [1:0] tx_lol_run_out,
	input wire logic dpd_grant_out,
	input wire logic cal_path_grant_out,
	input wire logic tx_observe_choice_out,
	input wire logic signed [15:0] lol_coef_tx1
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	a_rx_on_chain: assert property (!(rx_qec_run_out & ~chain_ack_out[1:0]))
		else $error("rx tracking off chain");
	a_rx_hold_ovl: assert property ($past(overload_high) |-> !rx_qec_update_out)
		else $error("update under overload");
	a_upd_in_run: assert property (!(rx_qec_update_out & ~rx_qec_run_out))
		else $error("update without run");
	a_obs_on_chain: assert property (!(orx_qec_run_out & ~chain_ack_out[5:4]))
		else $error("obs tracking off chain");
	a_path_excl: assert property (!(dpd_grant_out && cal_path_grant_out))
		else $error("path granted twice");
	a_tx_has_path: assert property ((tx_qec_run_out | tx_lol_run_out) != 2'h0
		|-> cal_path_grant_out && $onehot({tx_qec_run_out, tx_lol_run_out}))
		else $error("tx tracking without path");
	a_leak_pa_on: assert property (tx_lol_run_out != 2'h0 |-> $past(pa_active))
		else $error("leak tracking with amp off");
	a_choice_tx: assert property (tx_lol_run_out != 2'h0
		|-> tx_observe_choice_out == tx_lol_run_out[1])
		else $error("select names wrong tx");
	a_choice_wait: assert property ($changed(tx_observe_choice_out)
		|-> tx_lol_run_out == 2'h0 [*4])
		else $error("leak run before settle");
	a_coef_at_end: assert property ($changed(lol_coef_tx1) |-> $past(tx_lol_run_out[0]))
		else $error("coef moved off instance end");
	c_grant: cover property (dpd_grant_out);
	c_leak2: cover property (tx_lol_run_out[1]);
	c_hold: cover property ($fell(rx_qec_update_out[0]));
endmodule
bind tcs_scheduler tcs_sched_props u_props (.sys_clk, .rstn, .overload_high,
	.pa_active, .chain_ack_out, .rx_qec_run_out, .rx_qec_update_out,
	.orx_qec_run_out, .tx_qec_run_out, .tx_lol_run_out, .dpd_grant_out,
	.cal_path_grant_out, .tx_observe_choice_out, .lol_coef_tx1);
`default_nettype wire

/* tcs_bbp_model.sv */
// Host model: capture requests and the feedback switch
`timescale 1ns/1ps
`default_nettype none
module tcs_bbp_model (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic tx_observe_choice_out,
	input wire logic cal_path_grant_out,
	input wire logic dpd_grant_out,
	input wire logic capture_want,
	input wire logic signed [15:0] meas_set1,
	input wire logic signed [15:0] meas_set2,
	output logic dpd_capture_req,
	output logic signed [15:0] lol_meas_tx1,
	output logic signed [15:0] lol_meas_tx2
);
	logic [3:0] route_ff;
	logic [2:0] hold_ff;
	logic req_ff;
	logic fed;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			route_ff <= 4'h0;
			hold_ff <= 3'h0;
			req_ff <= 1'h0;
		end else begin
			// Switch lags the select, well inside the settle time
			route_ff <= {route_ff[2:0], tx_observe_choice_out};
			hold_ff <= dpd_grant_out ? hold_ff + 3'h1 : 3'h0;
			if (capture_want)
				req_ff <= 1'h1;
			else if (hold_ff == 3'h7)
				req_ff <= 1'h0;
		end
	end
	assign dpd_capture_req = req_ff;
	// Unsettled or unrouted loop gives no usable data
	assign fed = cal_path_grant_out && route_ff == {4{route_ff[0]}};
	assign lol_meas_tx1 = fed && !route_ff[0] ? meas_set1 : ~meas_set1;
	assign lol_meas_tx2 = fed && route_ff[0] ? meas_set2 : ~meas_set2;
endmodule
`default_nettype wire

/* tcs_tb.sv */
// Self-checking bench for the tracking calibration scheduler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hf, orx_gpio_pin = 4'h0, err_src_in = 4'h0;
	logic [1:0] rx_chain_enable_pin = 2'h0, tx_chain_enable_pin = 2'h0;
	logic tdd_rx_period = 1'h0, tdd_orx_period = 1'h0, overload_high = 1'h0;
	logic pa_active = 1'h0, capture_want = 1'h0, avs_waitrequest;
	logic signed [15:0] meas_set1 = 16'h0064, meas_set2 = 16'h0032;
	logic signed [15:0] lol_meas_tx1, lol_meas_tx2, lol_coef_tx1, lol_coef_tx2;
	logic [5:0] chain_ack_out;
	logic [1:0] rx_qec_run_out, rx_qec_update_out, orx_qec_run_out;
	logic [1:0] tx_qec_run_out, tx_lol_run_out;
	logic dpd_capture_req, dpd_grant_out, cal_path_grant_out;
	logic tx_observe_choice_out, general_error_irq;
	logic [7:0] watch;
	int fail_count = 0;
	int n_checks = 0;
	assign watch = {general_error_irq, dpd_grant_out, tx_lol_run_out,
		tx_qec_run_out, 2'h0};
	always #20 sys_clk = ~sys_clk;
	tcs_scheduler #(.ADAPT_TICK(16), .SETTLE_LEN(8)) dut (.sys_clk, .rstn,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .rx_chain_enable_pin,
		.tx_chain_enable_pin, .orx_gpio_pin, .tdd_rx_period, .tdd_orx_period,
		.overload_high, .pa_active, .dpd_capture_req, .lol_meas_tx1,
		.lol_meas_tx2, .err_src_in, .chain_ack_out, .rx_qec_run_out,
		.rx_qec_update_out, .orx_qec_run_out, .tx_qec_run_out, .tx_lol_run_out,
		.dpd_grant_out, .cal_path_grant_out, .tx_observe_choice_out,
		.lol_coef_tx1, .lol_coef_tx2, .general_error_irq);
	tcs_bbp_model host (.sys_clk, .rstn, .tx_observe_choice_out,
		.cal_path_grant_out, .dpd_grant_out, .capture_want, .meas_set1,
		.meas_set2, .dpd_capture_req, .lol_meas_tx1, .lol_meas_tx2);
	task automatic finish_test;
		if (fail_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, s);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic wq;
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// Read at the edge: values are those launched before it
		do begin
			@(posedge sys_clk);
			wq = avs_waitrequest;
			q = avs_readdata;
			n++;
		end while (wq !== 1'h0 && n < 20);
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		if (wq !== 1'h0) begin
			fail_count++;
			finish_test;
		end
	endtask
	task automatic wt(input int b, input logic v);
		int n;
		for (n = 0; watch[b] !== v; n++) begin
			@(negedge sys_clk);
			if (n > 5000) begin
				fail_count++;
				finish_test;
			end
		end
	endtask
	task automatic do_reset;
		@(posedge sys_clk);
		rstn <= 1'h0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'h1;
	endtask
	task automatic t_regs;
		bus(1'h0, 8'h14, 32'h0000_0000);
		chk("mask", {28'h0, tcs_pkg::ERR_MASK_RST}, q);
		@(posedge sys_clk);
		avs_byteenable <= 4'he;
		bus(1'h1, 8'h14, 32'h0000_0000);
		avs_byteenable <= 4'hf;
		bus(1'h0, 8'h14, 32'h0000_0000);
		chk("mask kept", {28'h0, tcs_pkg::ERR_MASK_RST}, q);
		bus(1'h1, 8'h1c, 32'hffff_ffff);
		bus(1'h0, 8'h1c, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, q);
	endtask
	task automatic t_rx;
		bus(1'h1, 8'h04, 32'h0000_0001);
		repeat (3) @(negedge sys_clk);
		chk("rx run", 32'h1, 32'(rx_qec_run_out));
		@(posedge sys_clk);
		overload_high <= 1'h1;
		repeat (3) @(negedge sys_clk);
		chk("rx upd", 32'h0, 32'(rx_qec_update_out));
		bus(1'h1, 8'h00, 32'h0000_0001);
		bus(1'h1, 8'h04, 32'h0000_0011);
		repeat (3) @(negedge sys_clk);
		chk("rx tdd", 32'h0, 32'(rx_qec_run_out));
		chk("obs tdd", 32'h0, 32'(orx_qec_run_out));
		@(posedge sys_clk);
		tdd_rx_period <= 1'h1;
		tdd_orx_period <= 1'h1;
		overload_high <= 1'h0;
		repeat (3) @(negedge sys_clk);
		chk("rx upd", 32'h1, 32'(rx_qec_update_out));
		chk("obs run", 32'h1, 32'(orx_qec_run_out));
	endtask
	task automatic t_pins;
		bus(1'h1, 8'h00, 32'h0000_000e);
		rx_chain_enable_pin <= 2'h2;
		tx_chain_enable_pin <= 2'h1;
		orx_gpio_pin <= 4'h6;
		repeat (3) @(negedge sys_clk);
		chk("ack", 32'h26, 32'(chain_ack_out));
		chk("choice inv", 32'h1, 32'(tx_observe_choice_out));
		wt(2, 1'h1);
	endtask
	task automatic t_tx;
		int i;
		bus(1'h1, 8'h00, 32'h0000_0000);
		bus(1'h1, 8'h08, 32'h0000_0001);
		bus(1'h0, 8'h08, 32'h0000_0000);
		chk("est cnt", 32'h6, q);
		bus(1'h1, 8'h08, 32'h0000_0002);
		bus(1'h0, 8'h08, 32'h0000_0000);
		chk("est cnt", 32'h36, q);
		bus(1'h1, 8'h04, 32'h0000_000c);
		repeat (20) @(negedge sys_clk);
		chk("tx run", 32'h0, 32'(tx_qec_run_out));
		bus(1'h1, 8'h04, 32'h0000_004c);
		wt(2, 1'h1);
		@(posedge sys_clk);
		pa_active <= 1'h1;
		bus(1'h1, 8'h08, 32'h0000_0003);
		for (i = 0; i < 6; i++) begin
			wt(4, 1'h1);
			wt(4, 1'h0);
			chk("coef", 32'h0, 32'(lol_coef_tx1));
		end
		chk("coef2", 32'h0, 32'(lol_coef_tx2));
		wt(5, 1'h1);
		chk("choice", 32'h1, 32'(tx_observe_choice_out));
		@(posedge sys_clk);
		meas_set1 <= 16'h008c;
		wt(4, 1'h1);
		wt(4, 1'h0);
		chk("coef", 32'hffff_fff6, 32'(lol_coef_tx1));
		@(posedge sys_clk);
		capture_want <= 1'h1;
		@(posedge sys_clk);
		capture_want <= 1'h0;
		wt(6, 1'h1);
		chk("cal grant", 32'h0, 32'(cal_path_grant_out));
		wt(6, 1'h0);
	endtask
	task automatic t_err;
		bus(1'h1, 8'h14, 32'h0000_000e);
		err_src_in <= 4'h2;
		@(posedge sys_clk);
		err_src_in <= 4'h0;
		repeat (3) @(negedge sys_clk);
		chk("irq", 32'h0, 32'(general_error_irq));
		bus(1'h0, 8'h10, 32'h0000_0000);
		chk("err", 32'h2, q);
		err_src_in <= 4'h1;
		@(posedge sys_clk);
		err_src_in <= 4'h0;
		wt(7, 1'h1);
		bus(1'h1, 8'h10, 32'h0000_0003);
		wt(7, 1'h0);
		@(posedge sys_clk);
		err_src_in <= 4'h8;
		bus(1'h0, 8'h10, 32'h0000_0000);
		err_src_in <= 4'h0;
		chk("err", 32'h8, q);
		do_reset;
		t_regs;
	endtask
	initial begin
		do_reset;
		t_regs;
		t_rx;
		t_pins;
		t_tx;
		t_err;
		finish_test;
	end
endmodule
`default_nettype wire
